// ===== common/lmu_pkg.sv
// Constants for the lighting unit register bank: offsets, fields, reset values, timing.
// Assumes a serial interface engine that issues single byte reads and writes.
// ****************************************************************************
// Operation
// R1: Control bit 7 turns internal keypad PWM dimming on or off.
// R2: Control bit 6 is the master enable for all keypad outputs.
// R3: Control bit 5 picks current sink (0) or switch mode (1); resets to 1.
// R4: Control bits 3, 2, 1 enable keypad channels one, two, three.
// R5: Brightness register bits 6..4 hold the keypad PWM balance.
// R6: Brightness register bits 3..1 hold the keypad PWM brightness level.
// R7: Brightness register bit 0 turns overlapping PWM mode on.
// R8: Limit fields 5:4, 3:2, 1:0 scale channel current to quarter steps.
// R9: Bits take their reset values; read-only bits read zero, ignore writes.
// R10: A keypad channel drives only with master and its own enable set.
// R11: Backlight slope bit picks 0.65 s or 1.3 s full-scale fade time.
// R12: Shared backlight bit makes both backlight outputs use the primary code.
// R13: Backlight current codes map linearly to 0.1 mA steps, zero is off.
// ****************************************************************************
package lmu_pkg;

  // ****************************************************************************
  // Register offsets
  // ****************************************************************************
  localparam logic [7:0] KEYP_CTRL_OFS  = 8'h00;
  localparam logic [7:0] KEYP_BRT_OFS   = 8'h01;
  localparam logic [7:0] KEYP_LIM_OFS   = 8'h02;
  localparam logic [7:0] BL_CTRL_OFS    = 8'h03;
  localparam logic [7:0] BL_MAIN_OFS    = 8'h04;
  localparam logic [7:0] BL_SUB_OFS     = 8'h05;
  localparam logic [7:0] GPIO_DIR_OFS   = 8'h06;
  localparam logic [7:0] GPIO_VAL_OFS   = 8'h07;
  localparam logic [7:0] PWR_EN_OFS     = 8'h0B;
  localparam logic [7:0] BOOST_V_OFS    = 8'h0D;
  localparam logic [7:0] EXT_PWM_OFS    = 8'h2B;

  // ****************************************************************************
  // Writable bit masks (zero bits are read-only and read back zero)
  // ****************************************************************************
  localparam logic [7:0] KEYP_CTRL_WM   = 8'hEE;
  localparam logic [7:0] KEYP_BRT_WM    = 8'h7F;
  localparam logic [7:0] KEYP_LIM_WM    = 8'h3F;
  localparam logic [7:0] BL_CTRL_WM     = 8'h3F;
  localparam logic [7:0] FULL_WM        = 8'hFF;
  localparam logic [7:0] GPIO_DIR_WM    = 8'h17;
  localparam logic [7:0] GPIO_VAL_WM    = 8'h07;
  localparam logic [7:0] PWR_EN_WM      = 8'h64;
  localparam logic [7:0] EXT_PWM_WM     = 8'h1F;

  // ****************************************************************************
  // Reset values
  // ****************************************************************************
  localparam logic [7:0] KEYP_CTRL_RST  = 8'h20;
  localparam logic [7:0] ZERO_RST       = 8'h00;
  localparam logic [7:0] PWR_EN_RST     = 8'h04;
  localparam logic [7:0] BOOST_V_RST    = 8'h08;

  // ****************************************************************************
  // Field positions
  // ****************************************************************************
  localparam int KEYP_DIM_BIT    = 7;
  localparam int KEYP_MASTER_BIT = 6;
  localparam int KEYP_STYLE_BIT  = 5;
  localparam int KEYP_CH1_BIT    = 3;
  localparam int BAL_LSB         = 4;
  localparam int LUM_LSB         = 1;
  localparam int OVL_BIT         = 0;
  localparam int LIM_CH1_LSB     = 4;
  localparam int BL_SLOPE_BIT    = 5;
  localparam int BL_FSEL_BIT     = 4;
  localparam int BL_FADE_BIT     = 3;
  localparam int BL_SHARED_BIT   = 2;
  localparam int BL_MAIN_BIT     = 1;
  localparam int BL_SUB_BIT      = 0;
  localparam int EXT_PIN_BIT     = 4;
  localparam int ACTIVE_BIT      = 6;
  localparam int BOOST_BIT       = 5;
  localparam int DUMMY_LOAD_BIT  = 2;
  localparam int EXT_CH1_BIT     = 4;
  localparam int EXT_MAIN_BIT    = 1;
  localparam int EXT_SUB_BIT     = 0;
  localparam int NUM_KEYS        = 3;

  // ****************************************************************************
  // Fade timing at 200 MHz
  // ****************************************************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned FADE_SHORT_NS = 650_000_000;
  localparam int unsigned FADE_LONG_NS  = 1_300_000_000;
  localparam int unsigned FADE_SHORT_CYC = FADE_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned FADE_LONG_CYC  = FADE_LONG_NS / CLK_PERIOD_NS;

endpackage : lmu_pkg

// ===== hw/lmu_keypad_chan.sv
// One keypad channel: output gating, current scale and external dimming select.
// Assumes its inputs come straight from register bits on the same clock.
module lmu_keypad_chan (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       master_on,
  input  wire logic       chan_on,
  input  wire logic [1:0] limit_code,
  input  wire logic       ext_dim_sel,
  output logic            drive_on,
  output logic [2:0]      limit_quarters,
  output logic            ext_dimming
);
  import lmu_pkg::*;

  // Gate and scale registered so the analog side sees glitch-free levels
  always_ff @(posedge mclk) begin
    if (rst) begin
      drive_on       <= 1'b0;
      limit_quarters <= 3'h1;
      ext_dimming    <= 1'b0;
    end else begin
      drive_on       <= master_on & chan_on;            // [R2] [R10]
      limit_quarters <= {1'b0, limit_code} + 3'h1;      // [R8]
      ext_dimming    <= ext_dim_sel;
    end
  end

endmodule // lmu_keypad_chan

// ===== hw/lmu_reg_bank.sv
// Byte-wide control register bank of the lighting unit and its decoded controls.
// Assumes the serial engine gives one-cycle read and write strobes with an address.
module lmu_reg_bank #(
  parameter int unsigned FADE_SHORT_CYCLES = lmu_pkg::FADE_SHORT_CYC,
  parameter int unsigned FADE_LONG_CYCLES  = lmu_pkg::FADE_LONG_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            keypad_dimming_on,
  output logic            keypad_drive_style,
  output logic [2:0]      keypad_balance,
  output logic [2:0]      keypad_luminance_level,
  output logic            keypad_overlap_on,
  output logic [2:0]      key_drive_on,
  output logic [8:0]      key_limit_quarters,
  output logic [2:0]      key_ext_dimming,
  output logic            main_on,
  output logic            sub_on,
  output logic            fade_on,
  output logic            fade_on_sub,
  output logic [31:0]     fade_time_cycles,
  output logic [7:0]      main_current_code,
  output logic [7:0]      sub_current_code,
  output logic            main_ext_dimming,
  output logic            sub_ext_dimming,
  output logic [2:0]      gpio_drive_dir,
  output logic [2:0]      gpio_out_val,
  output logic            ext_pwm_pin_on,
  output logic            active_not_sleep,
  output logic            boost_on,
  output logic            step_up_dummy_load_on,
  output logic [7:0]      boost_voltage_code
);
  import lmu_pkg::*;

  logic [7:0] keypad_led_control_reg;
  logic [7:0] keypad_balance_brightness_reg;
  logic [7:0] keypad_current_limit_reg;
  logic [7:0] backlight_control_reg;
  logic [7:0] primary_backlight_current_reg;
  logic [7:0] secondary_backlight_current_reg;
  logic [7:0] gpio_direction_control_reg;
  logic [7:0] gpio_value_reg;
  logic [7:0] power_enables_reg;
  logic [7:0] boost_voltage_setting_reg;
  logic [7:0] external_pwm_select_reg;
  logic [7:0] rdata_next;

  // ****************************************************************************
  // Register writes
  // ****************************************************************************

  // Masked store keeps read-only bits at zero whatever the host sends
  always_ff @(posedge mclk) begin
    if (rst) begin
      keypad_led_control_reg          <= KEYP_CTRL_RST;   // [R3] [R9]
      keypad_balance_brightness_reg   <= ZERO_RST;        // [R9]
      keypad_current_limit_reg        <= ZERO_RST;
      backlight_control_reg           <= ZERO_RST;
      primary_backlight_current_reg   <= ZERO_RST;
      secondary_backlight_current_reg <= ZERO_RST;
      gpio_direction_control_reg      <= ZERO_RST;
      gpio_value_reg                  <= ZERO_RST;
      power_enables_reg               <= PWR_EN_RST;      // [R9]
      boost_voltage_setting_reg       <= BOOST_V_RST;
      external_pwm_select_reg         <= ZERO_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        KEYP_CTRL_OFS: keypad_led_control_reg <= reg_wdata & KEYP_CTRL_WM; // [R9]
        KEYP_BRT_OFS:  keypad_balance_brightness_reg <= reg_wdata & KEYP_BRT_WM;
        KEYP_LIM_OFS:  keypad_current_limit_reg <= reg_wdata & KEYP_LIM_WM;
        BL_CTRL_OFS:   backlight_control_reg <= reg_wdata & BL_CTRL_WM;
        BL_MAIN_OFS:   primary_backlight_current_reg <= reg_wdata & FULL_WM;
        BL_SUB_OFS:    secondary_backlight_current_reg <= reg_wdata & FULL_WM;
        GPIO_DIR_OFS:  gpio_direction_control_reg <= reg_wdata & GPIO_DIR_WM;
        GPIO_VAL_OFS:  gpio_value_reg <= reg_wdata & GPIO_VAL_WM;
        PWR_EN_OFS:    power_enables_reg <= reg_wdata & PWR_EN_WM;
        BOOST_V_OFS:   boost_voltage_setting_reg <= reg_wdata & FULL_WM;
        EXT_PWM_OFS:   external_pwm_select_reg <= reg_wdata & EXT_PWM_WM;
        default: ;  // Unmapped writes are dropped
      endcase
    end
  end

  // Stores obey the writable masks, so reserved places stay zero
  ro_bits_a: assert property (@(posedge mclk) disable iff (rst) // [R9]
    (keypad_led_control_reg & ~KEYP_CTRL_WM) == 8'h00 &&
    (power_enables_reg & ~PWR_EN_WM) == 8'h00)
    else $error("read-only bit holds a one");

  pwr_write_a: assert property (@(posedge mclk) disable iff (rst) // [R9]
    reg_wr && reg_addr == PWR_EN_OFS |=> power_enables_reg == ($past(reg_wdata) & PWR_EN_WM))
    else $error("enables write not masked");

  limit_write_a: assert property (@(posedge mclk) disable iff (rst) // [R8]
    reg_wr && reg_addr == KEYP_LIM_OFS |=>
    keypad_current_limit_reg == {2'b00, $past(reg_wdata[5:0])})
    else $error("limit fields not taken from write");

  style_write_a: assert property (@(posedge mclk) disable iff (rst) // [R3]
    reg_wr && reg_addr == KEYP_CTRL_OFS |=> keypad_drive_style == $past(reg_wdata[5]))
    else $error("drive style not taken from write");

  // ****************************************************************************
  // Register reads
  // ****************************************************************************

  // Read mux; unmapped offsets answer zero
  always_comb begin
    case (reg_addr)
      KEYP_CTRL_OFS: rdata_next = keypad_led_control_reg;
      KEYP_BRT_OFS:  rdata_next = keypad_balance_brightness_reg;
      KEYP_LIM_OFS:  rdata_next = keypad_current_limit_reg;
      BL_CTRL_OFS:   rdata_next = backlight_control_reg;
      BL_MAIN_OFS:   rdata_next = primary_backlight_current_reg;
      BL_SUB_OFS:    rdata_next = secondary_backlight_current_reg;
      GPIO_DIR_OFS:  rdata_next = gpio_direction_control_reg;
      GPIO_VAL_OFS:  rdata_next = gpio_value_reg;
      PWR_EN_OFS:    rdata_next = power_enables_reg;
      BOOST_V_OFS:   rdata_next = boost_voltage_setting_reg;
      EXT_PWM_OFS:   rdata_next = external_pwm_select_reg;
      default:       rdata_next = 8'h00;
    endcase
  end

  // Read data held until the next read so the engine may shift it out slowly
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // Read data moves only on a read strobe; engine may shift it out late
  rdata_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  pwr_read_a: assert property (@(posedge mclk) disable iff (rst) // [R9]
    reg_rd && reg_addr == PWR_EN_OFS |=> reg_rdata == $past(power_enables_reg))
    else $error("enables register read back wrong");

  // ****************************************************************************
  // Keypad channels
  // ****************************************************************************
  for (genvar i = 0; i < NUM_KEYS; i++) begin : g_key
    lmu_keypad_chan u_chan (
      .mclk           (mclk),
      .rst            (rst),
      .master_on      (keypad_led_control_reg[KEYP_MASTER_BIT]),           // [R2]
      .chan_on        (keypad_led_control_reg[KEYP_CH1_BIT - i]),          // [R4]
      .limit_code     (keypad_current_limit_reg[LIM_CH1_LSB - 2*i +: 2]),  // [R8]
      .ext_dim_sel    (external_pwm_select_reg[EXT_CH1_BIT - i]),
      .drive_on       (key_drive_on[i]),
      .limit_quarters (key_limit_quarters[3*i +: 3]),
      .ext_dimming    (key_ext_dimming[i])
    );
  end

  // Channel gating, scale and select one flop stage after the registers
  ch2_gate_a: assert property (@(posedge mclk) disable iff (rst) // [R10]
    ##1 key_drive_on[1] == ($past(keypad_led_control_reg[6]) && $past(keypad_led_control_reg[2])))
    else $error("channel two gating wrong");

  ch3_gate_a: assert property (@(posedge mclk) disable iff (rst) // [R10]
    ##1 key_drive_on[2] == ($past(keypad_led_control_reg[6]) && $past(keypad_led_control_reg[1])))
    else $error("channel three gating wrong");

  ch1_limit_a: assert property (@(posedge mclk) disable iff (rst) // [R8]
    ##1 key_limit_quarters[2:0] == {1'b0, $past(keypad_current_limit_reg[5:4])} + 3'h1)
    else $error("channel one limit scale wrong");

  ext_dim_a: assert property (@(posedge mclk) disable iff (rst)
    ##1 key_ext_dimming[0] == $past(external_pwm_select_reg[EXT_CH1_BIT]))
    else $error("channel one external dimming select wrong");

  // ****************************************************************************
  // Decoded control outputs
  // ****************************************************************************

  // Keypad mode levels straight from register flops
  assign keypad_dimming_on      = keypad_led_control_reg[KEYP_DIM_BIT];    // [R1]
  assign keypad_drive_style     = keypad_led_control_reg[KEYP_STYLE_BIT];  // [R3]
  assign keypad_balance         = keypad_balance_brightness_reg[BAL_LSB +: 3]; // [R5]
  assign keypad_luminance_level = keypad_balance_brightness_reg[LUM_LSB +: 3]; // [R6]
  assign keypad_overlap_on      = keypad_balance_brightness_reg[OVL_BIT];  // [R7]

  // Backlight enables and fade selects
  assign main_on               = backlight_control_reg[BL_MAIN_BIT];
  assign sub_on                = backlight_control_reg[BL_SUB_BIT];
  assign fade_on               = backlight_control_reg[BL_FADE_BIT];
  assign fade_on_sub           = backlight_control_reg[BL_FSEL_BIT];

  // External dimming selects for the backlight
  assign main_ext_dimming      = external_pwm_select_reg[EXT_MAIN_BIT];
  assign sub_ext_dimming       = external_pwm_select_reg[EXT_SUB_BIT];

  // GPIO direction and data; no pin input path here
  assign gpio_drive_dir        = gpio_direction_control_reg[2:0];
  assign gpio_out_val          = gpio_value_reg[2:0];
  assign ext_pwm_pin_on        = gpio_direction_control_reg[EXT_PIN_BIT];

  // Power state and boost voltage
  assign active_not_sleep      = power_enables_reg[ACTIVE_BIT];
  assign boost_on              = power_enables_reg[BOOST_BIT];
  assign step_up_dummy_load_on = power_enables_reg[DUMMY_LOAD_BIT];
  assign boost_voltage_code    = boost_voltage_setting_reg;

  // Fade length follows the slope bit; sim overrides keep the counts small
  always_ff @(posedge mclk) begin
    if (rst) begin
      fade_time_cycles <= FADE_SHORT_CYCLES;
    end else begin
      fade_time_cycles <= backlight_control_reg[BL_SLOPE_BIT] ?
                          FADE_LONG_CYCLES : FADE_SHORT_CYCLES;        // [R11]
    end
  end

  // Primary code passed through; units are 0.1 mA
  always_ff @(posedge mclk) begin
    if (rst) begin
      main_current_code <= 8'h00;
    end else begin
      main_current_code <= primary_backlight_current_reg;              // [R13]
    end
  end

  // Shared mode drives the secondary output from the primary code
  always_ff @(posedge mclk) begin
    if (rst) begin
      sub_current_code <= 8'h00;
    end else begin
      sub_current_code <= backlight_control_reg[BL_SHARED_BIT] ?
                          primary_backlight_current_reg :
                          secondary_backlight_current_reg;             // [R12] [R13]
    end
  end

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  dim_write_a: assert property (@(posedge mclk) disable iff (rst)   // [R1]
    reg_wr && reg_addr == KEYP_CTRL_OFS |=> keypad_dimming_on == $past(reg_wdata[7]))
    else $error("keypad dimming bit not taken from write");

  master_gate_a: assert property (@(posedge mclk) disable iff (rst) // [R2]
    !keypad_led_control_reg[KEYP_MASTER_BIT] |=> key_drive_on == 3'h0)
    else $error("keypad driven while master off");

  style_reset_a: assert property (@(posedge mclk)                   // [R3]
    $past(rst) && !rst |-> keypad_drive_style == 1'b1 && keypad_led_control_reg == KEYP_CTRL_RST)
    else $error("drive style not switch mode after reset");

  chan_write_a: assert property (@(posedge mclk) disable iff (rst)  // [R4]
    reg_wr && reg_addr == KEYP_CTRL_OFS && reg_wdata[6] ##1 !(reg_wr && reg_addr == KEYP_CTRL_OFS)
    |=> key_drive_on == {$past(reg_wdata[1], 2), $past(reg_wdata[2], 2), $past(reg_wdata[3], 2)})
    else $error("channel enables not mapped to bits 3..1");

  bal_write_a: assert property (@(posedge mclk) disable iff (rst)   // [R5]
    reg_wr && reg_addr == KEYP_BRT_OFS |=> keypad_balance == $past(reg_wdata[6:4]))
    else $error("balance field wrong");

  lum_write_a: assert property (@(posedge mclk) disable iff (rst)   // [R6]
    reg_wr && reg_addr == KEYP_BRT_OFS |=> keypad_luminance_level == $past(reg_wdata[3:1]))
    else $error("brightness field wrong");

  ovl_write_a: assert property (@(posedge mclk) disable iff (rst)   // [R7]
    reg_wr && reg_addr == KEYP_BRT_OFS |=> keypad_overlap_on == $past(reg_wdata[0]))
    else $error("overlap bit wrong");

  limit_scale_a: assert property (@(posedge mclk) disable iff (rst) // [R8]
    ##1 key_limit_quarters[8:6] == {1'b0, $past(keypad_current_limit_reg[1:0])} + 3'h1)
    else $error("channel three limit scale wrong");

  ro_read_a: assert property (@(posedge mclk) disable iff (rst)     // [R9]
    reg_rd && reg_addr == KEYP_CTRL_OFS |=> reg_rdata[4] == 1'b0 && reg_rdata[0] == 1'b0)
    else $error("read-only control bits not zero");

  pwr_reset_a: assert property (@(posedge mclk)                     // [R9]
    $past(rst) && !rst |-> power_enables_reg == PWR_EN_RST && boost_voltage_code == BOOST_V_RST)
    else $error("power or boost reset value wrong");

  chan_gate_a: assert property (@(posedge mclk) disable iff (rst)   // [R10]
    ##1 key_drive_on[0] == ($past(keypad_led_control_reg[6]) && $past(keypad_led_control_reg[3])))
    else $error("channel one gating wrong");

  fade_time_a: assert property (@(posedge mclk) disable iff (rst)   // [R11]
    ##1 fade_time_cycles == ($past(backlight_control_reg[5]) ? FADE_LONG_CYCLES : FADE_SHORT_CYCLES))
    else $error("fade time does not follow slope bit");

  shared_code_a: assert property (@(posedge mclk) disable iff (rst) // [R12]
    backlight_control_reg[BL_SHARED_BIT] |=> sub_current_code == $past(primary_backlight_current_reg))
    else $error("secondary not following primary code");

  own_code_a: assert property (@(posedge mclk) disable iff (rst)    // [R13]
    !backlight_control_reg[BL_SHARED_BIT] |=> sub_current_code == $past(secondary_backlight_current_reg)
    && main_current_code == $past(primary_backlight_current_reg))
    else $error("backlight current code not passed through");

endmodule // lmu_reg_bank

// ===== tb/lmu_host_model.sv
// Host side model: stands for the serial engine issuing single byte reads and writes.
// Assumes callers enter each task just after a rising edge of mclk.
module lmu_host_model (
  input  wire logic       mclk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One strobe cycle; strobes stay up so calls can run back to back
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = w ? d : ~reg_wdata;
    @(posedge mclk);
    #1;
  endtask

  // Released lines flip so a stale value never looks valid
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
    idle();
  endtask

  // Read data is taken one edge after the strobe, before it changes
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    op(1'b0, 1'b1, a, 8'h00);
    d = reg_rdata;
    idle();
  endtask
endmodule // lmu_host_model

// ===== tb/lmu_reg_bank_bench.sv
// Self-checking bench for the lighting unit register bank.
// Assumes lmu_pkg and the host model are compiled first; short fade counts in use.
module lmu_reg_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import lmu_pkg::*;

  localparam int unsigned FS = 13;
  localparam int unsigned FL = 26;
  logic mclk, rst, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic kd, ks, ko, mo, so, fo, fos, me, se, ep, an, bo, dl;
  logic [2:0] kb, kl, kdrv, kext, gd, gv;
  logic [8:0] klq;
  logic [31:0] ft;
  logic [7:0] mc, sc, bv;
  int err_total = 0;
  int tests_run = 0;
  // Register table: offset, reset value, writable mask
  logic [7:0] ofs [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0B,
                           8'h0D, 8'h2B};
  logic [7:0] rsv [11] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04,
                           8'h08, 8'h00};
  logic [7:0] msk [11] = '{8'hEE, 8'h7F, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'h17, 8'h07, 8'h64,
                           8'hFF, 8'h1F};
  logic [7:0] bl [4] = '{8'h00, 8'h3F, 8'h1B, 8'h24};

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  lmu_host_model lmu_host_model_i (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  lmu_reg_bank #(.FADE_SHORT_CYCLES(FS), .FADE_LONG_CYCLES(FL)) lmu_reg_bank_i (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .keypad_dimming_on(kd),
    .keypad_drive_style(ks), .keypad_balance(kb), .keypad_luminance_level(kl),
    .keypad_overlap_on(ko), .key_drive_on(kdrv), .key_limit_quarters(klq),
    .key_ext_dimming(kext), .main_on(mo), .sub_on(so), .fade_on(fo), .fade_on_sub(fos),
    .fade_time_cycles(ft), .main_current_code(mc), .sub_current_code(sc),
    .main_ext_dimming(me), .sub_ext_dimming(se), .gpio_drive_dir(gd), .gpio_out_val(gv),
    .ext_pwm_pin_on(ep), .active_not_sleep(an), .boost_on(bo),
    .step_up_dummy_load_on(dl), .boost_voltage_code(bv));

  // ****************************************************************************
  // Compare and closing tasks
  // ****************************************************************************
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Outputs zero-extended so one task covers every width
  task automatic chk_out(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Reset held n cycles, then outputs and every register checked
  task automatic do_reset(input int n);
    rst = 1'b1;
    repeat (n) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk_out("limit_q", 32'h049, {23'd0, klq});
    chk_out("drive", 32'd0, {29'd0, kdrv});
    chk_out("fade", FS, ft);
    chk_out("currents", 32'd0, {16'd0, mc, sc});
    chk_reg("rdata", 8'h00, reg_rdata);
    for (int i = 0; i < 11; i++) begin
      lmu_host_model_i.rd(ofs[i], rv);
      chk_reg("reset", rsv[i], rv);
    end
  endtask

  // ****************************************************************************
  // Main sequence
  // ****************************************************************************
  initial begin
    logic [7:0] w;
    logic [1:0] c1, c2, c3;
    rst = 1'b1;
    do_reset(10);
    // Read-only bits, writable bits and unmapped places
    for (int i = 0; i < 11; i++) begin
      lmu_host_model_i.wr(ofs[i], 8'hFF);
      lmu_host_model_i.rd(ofs[i], rv);
      chk_reg("ones", msk[i], rv);
      lmu_host_model_i.wr(ofs[i], 8'h00);
      lmu_host_model_i.rd(ofs[i], rv);
      chk_reg("zeros", 8'h00, rv);
    end
    foreach (ofs[i]) begin
      lmu_host_model_i.wr(ofs[i] ^ 8'h80, 8'hFF);
      lmu_host_model_i.rd(ofs[i] ^ 8'h80, rv);
      chk_reg("unmapped", 8'h00, rv);
      lmu_host_model_i.rd(ofs[i], rv);
      chk_reg("no_alias", 8'h00, rv);
    end
    // Keypad control: every master and channel combination
    for (int v = 0; v < 16; v++) begin
      w = {v[0], v[3], v[1], 1'b0, v[0], v[1], v[2], 1'b0};
      lmu_host_model_i.wr(8'h00, w);
      chk_out("dim", v[0], kd);
      chk_out("style", v[1], ks);
      chk_out("drive", v[3] ? v[2:0] : 0, kdrv);
    end
    // Balance, brightness and overlap fields
    foreach (bl[i]) begin
      w = bl[i] ^ 8'h5B;
      lmu_host_model_i.wr(8'h01, w);
      chk_out("balance", w[6:4], kb);
      chk_out("lum", w[3:1], kl);
      chk_out("overlap", w[0], ko);
    end
    // Current limit codes, each channel sees every code
    for (int k = 0; k < 4; k++) begin
      c1 = k[1:0];
      c2 = c1 + 2'd1;
      c3 = c1 + 2'd2;
      lmu_host_model_i.wr(8'h02, {2'b00, c1, c2, c3});
      chk_out("limit_q", {{1'b0, c3} + 3'd1, {1'b0, c2} + 3'd1, {1'b0, c1} + 3'd1}, klq);
    end
    // Backlight control with distinct primary and secondary codes
    lmu_host_model_i.wr(8'h04, 8'h5A);
    lmu_host_model_i.wr(8'h05, 8'hC3);
    foreach (bl[i]) begin
      lmu_host_model_i.wr(8'h03, bl[i]);
      chk_out("bl_en", {bl[i][4:3], bl[i][1:0]}, {fos, fo, mo, so});
      chk_out("main_code", 8'h5A, mc);
      chk_out("sub_code", bl[i][2] ? 8'h5A : 8'hC3, sc);
      chk_out("fade", bl[i][5] ? FL : FS, ft);
    end
    // External dimming selects in four patterns, two opposite pairs
    foreach (bl[i]) begin
      w = bl[i] ^ 8'h15;
      lmu_host_model_i.wr(8'h2B, w);
      chk_out("ext", {w[2], w[3], w[4], w[1], w[0]}, {kext, me, se});
    end
    // General purpose, enables and boost outputs
    lmu_host_model_i.wr(8'h06, 8'h15);
    lmu_host_model_i.wr(8'h07, 8'h05);
    lmu_host_model_i.wr(8'h0B, 8'h60);
    lmu_host_model_i.wr(8'h0D, 8'h12);
    chk_out("gpio", {4'hE, 3'b101, 3'b101}, {ep, an, bo, dl, gd, gv});
    chk_out("boost_v", 8'h12, bv);
    // Write and read in one cycle return the old byte, then the new one next cycle
    lmu_host_model_i.op(1'b1, 1'b1, 8'h05, 8'hA5);
    chk_reg("same_cycle", 8'hC3, reg_rdata);
    lmu_host_model_i.op(1'b0, 1'b1, 8'h05, 8'h00);
    chk_reg("next_cycle", 8'hA5, reg_rdata);
    lmu_host_model_i.idle();
    // Second reset in mid-run
    do_reset(2);
    report_and_stop();
  end

  // Watchdog well past the expected run of about three hundred cycles
  initial begin
    #(5 * 20000);
    err_total++;
    report_and_stop();
  end
endmodule // lmu_reg_bank_bench
